// ===== src/bzcfg_top.sv
// Implementation choice: the strobed register port.
`default_nettype none
// How it works
// - Sample rate follows master clock and rate bit; filter codes 1-3 enable the low-pass, 0 bypasses it.
// - An unsupported rate and filter pair is replaced by the lowest cut-off in the cut-off readback; o_impedance_lowpass_sel keeps the written code.
// - The modulation frequency is looked up from the frequency code and master clock choice.
// - Frequency codes 101x and 11xx all give the lowest modulation frequency.
// - Codes 0001 to 0011 are shifted to reduce crosstalk with the ECG path.
// - A read/write low-current config register sits at offset 0x1a.
// - A main config change may break the sample record, shown by a discontinuity flag.
// - A main config change may alter the sample time step.
// - The resync command restores timing and clears the discontinuity flag.
// - Bit 23 selects high or low drive range; low range needs magnitude code 001.
// - Bit 19 doubles the low-range current.
// - Bits 3:0 set the low-range magnitude, codes 0 to 6 valid.
module bzcfg_top (
  // Clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_reset_n,
  // Register port
  input  wire logic [7:0]  i_addr,
  input  wire logic [23:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [23:0] o_rdata,
  // Configuration outputs
  output logic      [1:0]  o_master_clock_select,
  output logic             o_impedance_sample_rate_sel,
  output logic      [1:0]  o_impedance_lowpass_sel,
  output logic             o_lowpass_enable,
  output logic      [23:0] o_modulation_freq_hz,
  output logic      [2:0]  o_drive_magnitude_code,
  output logic             o_drive_range_high_sel,
  output logic             o_low_range_double_sel,
  output logic      [3:0]  o_low_range_magnitude_code,
  output logic      [15:0] o_low_current_na,
  output logic             o_test_load_enable,
  output logic      [1:0]  o_test_load_value_sel,
  output logic      [3:0]  o_common_mode_resistance_sel,
  // Timing
  output logic             o_resync_pulse,
  output logic             o_step_changed,
  output logic             o_discontinuity
);
  logic [23:0] lc_q, lc_d;
  logic [23:0] mc_q, mc_d;
  logic [23:0] gc_q, gc_d;
  logic [23:0] rdata_q, rdata_d;
  logic        resync_q, resync_d;
  logic        step_q, step_d;
  logic        disc_q, disc_d;
  logic [6:0]  status;
  logic [23:0] freq_hz;
  logic [23:0] freq_q;
  logic [1:0]  lpf_eff;
  logic [15:0] lc_na;
  logic [15:0] lc_na_q;
  logic [23:0] lpf_mhz;
  logic        rate_sel;
  logic [1:0]  mstr;
  logic [2:0]  mag;
  logic [3:0]  fcode;

  // Highest drive magnitude code allowed per frequency code
  function automatic logic [2:0] max_mag(input logic [3:0] code);
    logic [2:0] m;
    m = 3'h1;
    if (code <= 4'h3) begin
      m = 3'h7;
    end else if (code == 4'h4) begin
      m = 3'h6;
    end else if (code == 4'h5) begin
      m = 3'h3;
    end else if (code == 4'h6) begin
      m = 3'h2;
    end
    return m;
  endfunction

  assign mstr     = gc_q[bzcfg_pkg::GC_MSTR_LSB +: 2];
  assign rate_sel = mc_q[bzcfg_pkg::MC_RATE_BIT];
  assign mag      = mc_q[bzcfg_pkg::MC_MAG_LSB +: 3];
  assign fcode    = mc_q[bzcfg_pkg::MC_FREQ_LSB +: 4];

  bzcfg_freq u_freq (
    .i_master_clock_select        (mstr),
    .i_drive_modulation_freq_code (fcode),
    .o_freq_hz                    (freq_hz)
  );

  // At the slow rate only the lowest cut-off is supported
  always_comb begin
    lpf_eff = mc_q[bzcfg_pkg::MC_LPF_LSB +: 2];
    if (rate_sel && lpf_eff != bzcfg_pkg::LPF_BYPASS) begin
      lpf_eff = bzcfg_pkg::LPF_LOW;
    end
  end

  // Cut-off in mHz, scaled by master clock
  always_comb begin
    lpf_mhz = 24'h000000;
    if (lpf_eff != bzcfg_pkg::LPF_BYPASS) begin
      case (mstr)
        2'h0:    lpf_mhz = 24'h001000;
        2'h3:    lpf_mhz = 24'h000f9c;
        default: lpf_mhz = 24'h000fa0;
      endcase
      lpf_mhz = lpf_mhz << (lpf_eff - 2'h1);
    end
  end

  // Low-range current in nA; invalid codes give zero
  always_comb begin
    logic [3:0] c;
    c = lc_q[bzcfg_pkg::LC_MAG_LSB +: 4];
    lc_na = 16'h0000;
    if (c > 4'h0 && c <= bzcfg_pkg::LC_MAG_MAX) begin
      lc_na = (c == 4'h1) ? bzcfg_pkg::LC_STEP_NA
            : 16'((c - 4'h1) * bzcfg_pkg::LC_STEP_NA * 2);
    end
    if (lc_q[bzcfg_pkg::LC_DOUBLE_BIT]) begin
      lc_na = lc_na << 1;
    end
    if (lc_q[bzcfg_pkg::LC_RANGE_BIT]) begin
      lc_na = 16'h0000;
    end
  end

  always_comb begin
    status = 7'h00;
    status[bzcfg_pkg::ST_LPF_SUBST] = (lpf_eff !=
      mc_q[bzcfg_pkg::MC_LPF_LSB +: 2]);
    status[bzcfg_pkg::ST_MAG_BAD]   = (mag > max_mag(fcode));
    status[bzcfg_pkg::ST_LC_MAG_BAD] =
      (lc_q[bzcfg_pkg::LC_MAG_LSB +: 4] > bzcfg_pkg::LC_MAG_MAX);
    status[bzcfg_pkg::ST_RANGE_BAD] = !lc_q[bzcfg_pkg::LC_RANGE_BIT] &&
      (mag != bzcfg_pkg::MAG_LOW_RANGE);
    status[bzcfg_pkg::ST_DISCONT]   = disc_q;
    status[bzcfg_pkg::ST_LPF_ON]    = (lpf_eff != bzcfg_pkg::LPF_BYPASS);
    status[bzcfg_pkg::ST_RATE_SEL]  = rate_sel;
  end

  // Register writes and command handling
  always_comb begin
    logic mc_hit;
    mc_hit   = i_wr && (i_addr == bzcfg_pkg::ADDR_MAIN_IMP_CFG);
    lc_d     = lc_q;
    mc_d     = mc_q;
    gc_d     = gc_q;
    resync_d = i_wr && (i_addr == bzcfg_pkg::ADDR_RESYNC_CMD);
    step_d   = 1'b0;
    disc_d   = disc_q;
    if (i_wr && i_addr == bzcfg_pkg::ADDR_LOW_DRIVE_CFG) begin
      lc_d = i_wdata & bzcfg_pkg::LC_DEFINED_MASK;
    end
    if (mc_hit) begin
      mc_d = i_wdata & bzcfg_pkg::MC_DEFINED_MASK;
    end
    if (i_wr && i_addr == bzcfg_pkg::ADDR_GENERAL_CFG) begin
      gc_d = i_wdata & bzcfg_pkg::GC_DEFINED_MASK;
    end
    // A change in rate or clock moves the time step
    if ((mc_hit && i_wdata[bzcfg_pkg::MC_RATE_BIT] != rate_sel) ||
        (gc_d != gc_q)) begin
      step_d = 1'b1;
    end
    if (resync_d) begin
      disc_d = 1'b0;
    end
    // Set wins over the resync clear in the same cycle
    if (mc_hit) begin
      disc_d = 1'b1;
    end
  end

  // Read data, one cycle after the strobe; unmapped reads zero
  always_comb begin
    rdata_d = 24'h000000;
    if (i_rd) begin
      case (i_addr)
        bzcfg_pkg::ADDR_LOW_DRIVE_CFG: rdata_d = lc_q;
        bzcfg_pkg::ADDR_MAIN_IMP_CFG:  rdata_d = mc_q;
        bzcfg_pkg::ADDR_GENERAL_CFG:   rdata_d = gc_q;
        bzcfg_pkg::ADDR_STATUS:        rdata_d = {17'h00000, status};
        bzcfg_pkg::ADDR_FREQ_HZ:       rdata_d = freq_hz;
        bzcfg_pkg::ADDR_LPF_MHZ:       rdata_d = lpf_mhz;
        bzcfg_pkg::ADDR_LOW_CURR_NA:   rdata_d = {8'h00, lc_na};
        default:                       rdata_d = 24'h000000;
      endcase
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      lc_q     <= bzcfg_pkg::LC_RESET;
      mc_q     <= bzcfg_pkg::MC_RESET;
      gc_q     <= 24'h000000;
      rdata_q  <= 24'h000000;
      resync_q <= 1'b0;
      step_q   <= 1'b0;
      disc_q   <= 1'b0;
      freq_q   <= 24'h000000;
    end else begin
      lc_q     <= lc_d;
      mc_q     <= mc_d;
      gc_q     <= gc_d;
      rdata_q  <= rdata_d;
      resync_q <= resync_d;
      step_q   <= step_d;
      disc_q   <= disc_d;
      freq_q   <= freq_hz;
    end
  end

  // Outputs straight from registers
  assign o_rdata                      = rdata_q;
  assign o_master_clock_select        = gc_q[bzcfg_pkg::GC_MSTR_LSB +: 2];
  assign o_impedance_sample_rate_sel  = mc_q[bzcfg_pkg::MC_RATE_BIT];
  assign o_impedance_lowpass_sel      = mc_q[bzcfg_pkg::MC_LPF_LSB +: 2];
  assign o_lowpass_enable             = mc_q[bzcfg_pkg::MC_LPF_LSB +: 2] != 2'h0;
  assign o_modulation_freq_hz         = freq_q;
  assign o_drive_magnitude_code       = mc_q[bzcfg_pkg::MC_MAG_LSB +: 3];
  assign o_drive_range_high_sel       = lc_q[bzcfg_pkg::LC_RANGE_BIT];
  assign o_low_range_double_sel       = lc_q[bzcfg_pkg::LC_DOUBLE_BIT];
  assign o_low_range_magnitude_code   = lc_q[bzcfg_pkg::LC_MAG_LSB +: 4];
  assign o_low_current_na             = 16'h0000 | lc_na_q;
  assign o_test_load_enable           = lc_q[bzcfg_pkg::LC_TLEN_BIT];
  assign o_test_load_value_sel        = lc_q[bzcfg_pkg::LC_TLV_LSB +: 2];
  assign o_common_mode_resistance_sel = lc_q[bzcfg_pkg::LC_CMRES_LSB +: 4];
  assign o_resync_pulse               = resync_q;
  assign o_step_changed               = step_q;
  assign o_discontinuity              = disc_q;

  // Registered, so the current figure lags the other low-current outputs by one cycle
  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      lc_na_q <= 16'h0000;
    end else begin
      lc_na_q <= lc_na;
    end
  end
endmodule
`default_nettype wire

// ===== src/bzcfg_pkg.sv
`default_nettype none
package bzcfg_pkg;
  // Register offsets
  localparam logic [7:0] ADDR_LOW_DRIVE_CFG  = 8'h1a;
  localparam logic [7:0] ADDR_MAIN_IMP_CFG   = 8'h18;
  localparam logic [7:0] ADDR_GENERAL_CFG    = 8'h10;
  localparam logic [7:0] ADDR_RESYNC_CMD     = 8'h09;
  localparam logic [7:0] ADDR_STATUS         = 8'h30;
  localparam logic [7:0] ADDR_FREQ_HZ        = 8'h31;
  localparam logic [7:0] ADDR_LPF_MHZ        = 8'h32;
  localparam logic [7:0] ADDR_LOW_CURR_NA    = 8'h33;

  localparam int DATA_W = 24;

  // Low-current register fields
  localparam int LC_RANGE_BIT  = 23;
  localparam int LC_DOUBLE_BIT = 19;
  localparam int LC_TLEN_BIT   = 14;
  localparam int LC_TLV_LSB    = 12;
  localparam int LC_CMRES_LSB  = 4;
  localparam int LC_MAG_LSB    = 0;
  localparam logic [23:0] LC_DEFINED_MASK = 24'h8870ff;
  localparam logic [23:0] LC_RESET        = 24'h000055;

  // Main config fields
  localparam int MC_RATE_BIT  = 23;
  localparam int MC_LPF_LSB   = 12;
  localparam int MC_FREQ_LSB  = 8;
  localparam int MC_MAG_LSB   = 4;
  localparam logic [23:0] MC_DEFINED_MASK = 24'h8030f0 | 24'h000f00;
  localparam logic [23:0] MC_RESET        = 24'h000800;

  // General config fields
  localparam int GC_MSTR_LSB = 20;
  localparam logic [23:0] GC_DEFINED_MASK = 24'h300000;

  // Status bits
  localparam int ST_LPF_SUBST   = 0;
  localparam int ST_MAG_BAD     = 1;
  localparam int ST_LC_MAG_BAD  = 2;
  localparam int ST_RANGE_BAD   = 3;
  localparam int ST_DISCONT     = 4;
  localparam int ST_LPF_ON      = 5;
  localparam int ST_RATE_SEL    = 6;

  localparam logic [1:0] LPF_BYPASS = 2'h0;
  localparam logic [1:0] LPF_LOW    = 2'h1;
  localparam logic [2:0] MAG_LOW_RANGE = 3'h1;
  localparam logic [3:0] LC_MAG_MAX    = 4'h6;
  localparam logic [15:0] LC_STEP_NA   = 16'h0037;
endpackage
`default_nettype wire

// ===== src/bzcfg_freq.sv
`default_nettype none
// Modulation frequency lookup in Hz
module bzcfg_freq (
  // Selection
  input  wire logic [1:0]  i_master_clock_select,
  input  wire logic [3:0]  i_drive_modulation_freq_code,
  // Result
  output logic      [23:0] o_freq_hz
);
  always_comb begin
    o_freq_hz = 24'h000000;
    case (i_drive_modulation_freq_code)
      4'h0: begin
        case (i_master_clock_select)
          2'h0:    o_freq_hz = 24'h020000;
          2'h3:    o_freq_hz = 24'h01f380;
          default: o_freq_hz = 24'h01f400;
        endcase
      end
      // Offset codes keep the drive away from the ECG band
      4'h1: begin
        o_freq_hz = (i_master_clock_select == 2'h1 ||
                     i_master_clock_select == 2'h2) ? 24'h013880
                                                   : 24'h014000;
      end
      4'h2: begin
        o_freq_hz = (i_master_clock_select == 2'h1 ||
                     i_master_clock_select == 2'h2) ? 24'h009c40
                                                   : 24'h00a000;
      end
      4'h3: begin
        o_freq_hz = (i_master_clock_select == 2'h1 ||
                     i_master_clock_select == 2'h2) ? 24'h004574
                                                   : 24'h00471c;
      end
      4'h4: begin
        case (i_master_clock_select)
          2'h0:    o_freq_hz = 24'h002000;
          2'h3:    o_freq_hz = 24'h001f38;
          default: o_freq_hz = 24'h001f40;
        endcase
      end
      4'h5: begin
        case (i_master_clock_select)
          2'h0:    o_freq_hz = 24'h001000;
          2'h3:    o_freq_hz = 24'h000f9c;
          default: o_freq_hz = 24'h000fa0;
        endcase
      end
      4'h6: begin
        case (i_master_clock_select)
          2'h0:    o_freq_hz = 24'h000800;
          2'h3:    o_freq_hz = 24'h0007ce;
          default: o_freq_hz = 24'h0007d0;
        endcase
      end
      4'h7: begin
        case (i_master_clock_select)
          2'h0:    o_freq_hz = 24'h000400;
          2'h3:    o_freq_hz = 24'h0003e7;
          default: o_freq_hz = 24'h0003e8;
        endcase
      end
      4'h8: begin
        o_freq_hz = (i_master_clock_select == 2'h0) ? 24'h000200
                                                   : 24'h0001f4;
      end
      4'h9: begin
        o_freq_hz = (i_master_clock_select == 2'h0) ? 24'h000100
                                                   : 24'h0000fa;
      end
      default: begin
        o_freq_hz = (i_master_clock_select == 2'h0) ? 24'h000080
                                                   : 24'h00007d;
      end
    endcase
  end
endmodule
`default_nettype wire

// ===== verification/bzcfg_chk_sva.sv
`default_nettype none
module bzcfg_chk (
  // Clock, reset and register port
  input wire logic        i_clock,
  input wire logic        i_reset_n,
  input wire logic [7:0]  i_addr,
  input wire logic [23:0] i_wdata,
  input wire logic        i_wr,
  input wire logic        i_rd,
  // Watched outputs
  input wire logic [23:0] o_rdata,
  input wire logic [1:0]  o_master_clock_select,
  input wire logic [1:0]  o_impedance_lowpass_sel,
  input wire logic        o_lowpass_enable,
  input wire logic        o_drive_range_high_sel,
  input wire logic        o_low_range_double_sel,
  input wire logic [15:0] o_low_current_na,
  input wire logic        o_resync_pulse,
  input wire logic        o_step_changed,
  input wire logic        o_discontinuity
);
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_reset_n);
  logic lc_w;
  logic mc_w;
  logic rs_w;
  logic gc_w;
  assign lc_w = i_wr && i_addr == bzcfg_pkg::ADDR_LOW_DRIVE_CFG;
  assign mc_w = i_wr && i_addr == bzcfg_pkg::ADDR_MAIN_IMP_CFG;
  assign rs_w = i_wr && i_addr == bzcfg_pkg::ADDR_RESYNC_CMD;
  assign gc_w = i_wr && i_addr == bzcfg_pkg::ADDR_GENERAL_CFG;

  rdata_idle_a: assert property (!i_rd |=> o_rdata == 24'h0)
    else $error("read data not zero outside a read");
  lc_reserved_a: assert property (i_rd && i_addr ==
    bzcfg_pkg::ADDR_LOW_DRIVE_CFG |=> (o_rdata & 24'h778f00) == 24'h0)
    else $error("reserved low-current bits read nonzero");
  range_bit_a: assert property (lc_w |=>
    o_drive_range_high_sel == $past(i_wdata[23]))
    else $error("range select not taken from bit 23");
  double_bit_a: assert property (lc_w |=>
    o_low_range_double_sel == $past(i_wdata[19]))
    else $error("double select not taken from bit 19");
  high_na_a: assert property (o_drive_range_high_sel &&
    $past(o_drive_range_high_sel) |-> o_low_current_na == 16'h0)
    else $error("low current nonzero in high range");
  resync_a: assert property (rs_w |=> o_resync_pulse &&
    !o_discontinuity) else $error("resync did not pulse or clear");
  pulse_src_a: assert property (o_resync_pulse |-> $past(i_wr) &&
    $past(i_addr) == bzcfg_pkg::ADDR_RESYNC_CMD)
    else $error("resync pulse without command");
  disc_hold_a: assert property (mc_w or (o_discontinuity &&
    !rs_w) |=> o_discontinuity) else $error("discontinuity lost");
  step_a: assert property (gc_w &&
    i_wdata[21:20] != o_master_clock_select |=> o_step_changed)
    else $error("step change not flagged");
  lpf_en_a: assert property (o_lowpass_enable ==
    (o_impedance_lowpass_sel != 2'h0)) else $error("lowpass enable wrong");

  cover property (rs_w ##1 o_resync_pulse);
  cover property (mc_w ##1 o_discontinuity);
  cover property (lc_w ##1 o_drive_range_high_sel);
endmodule
bind bzcfg_top bzcfg_chk u_chk (.*);
`default_nettype wire

// ===== verification/tb_top.sv
`default_nettype none
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin \
  n_fail++; $display("Error %s expected %h seen %h", n, e, g); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        i_clock = 1'h0, i_reset_n = 1'h0, i_wr = 1'h0, i_rd = 1'h0;
  logic [7:0]  i_addr = 8'h0;
  logic [23:0] i_wdata = 24'h0, o_rdata, o_modulation_freq_hz, d, s;
  logic [1:0]  o_master_clock_select, o_impedance_lowpass_sel, l;
  logic [1:0]  o_test_load_value_sel;
  logic [2:0]  o_drive_magnitude_code, g;
  logic [3:0]  o_low_range_magnitude_code, o_common_mode_resistance_sel;
  logic [15:0] o_low_current_na;
  logic        o_impedance_sample_rate_sel, o_lowpass_enable, r;
  logic        o_drive_range_high_sel, o_low_range_double_sel;
  logic        o_test_load_enable, o_resync_pulse, o_step_changed;
  logic        o_discontinuity;
  int          n_fail = 0, checks_done = 0, seed = 32'h4586c6a6;

  bzcfg_top DUT (.*);
  always #5 i_clock = ~i_clock;

  task automatic wr(input logic [7:0] a, input logic [23:0] v);
    @(posedge i_clock);
    i_addr <= a;
    i_wdata <= v;
    i_wr <= 1'h1;
    @(posedge i_clock);
    i_wr <= 1'h0;
  endtask
  // Read data stand only in the cycle after the strobe, so sample mid-cycle
  task automatic rd(input logic [7:0] a, output logic [23:0] v);
    @(posedge i_clock);
    i_addr <= a;
    i_rd <= 1'h1;
    @(posedge i_clock);
    i_rd <= 1'h0;
    @(negedge i_clock);
    v = o_rdata;
  endtask
  function automatic logic [23:0] fhz(input logic [1:0] m,
                                      input logic [3:0] c);
    int t[3][11] = '{
      '{131072, 81920, 40960, 18204, 8192, 4096, 2048, 1024, 512, 256, 128},
      '{128000, 80000, 40000, 17780, 8000, 4000, 2000, 1000, 500, 250, 125},
      '{127872, 81920, 40960, 18204, 7992, 3996, 1998, 999, 500, 250, 125}};
    int k = m == 2'h0 ? 0 : (m == 2'h3 ? 2 : 1);
    return 24'(t[k][c > 4'h9 ? 10 : int'(c)]);
  endfunction
  function automatic logic ok(input logic [3:0] c, input logic [2:0] m);
    return c < 4'h4 || (c == 4'h4 && m != 3'h7) || (c == 4'h5 && m < 3'h4)
      || (c == 4'h6 && m < 3'h3) || m < 3'h2;
  endfunction
  function automatic logic [15:0] na(input logic [23:0] v);
    logic [15:0] x;
    x = v[3:0] == 4'h1 ? 16'h37 : 16'h6e * (16'(v[3:0]) - 16'h1);
    if (v[3:0] == 4'h0 || v[3:0] > 4'h6 || v[23]) x = 16'h0;
    return v[19] ? x << 1 : x;
  endfunction
  task automatic test_done();
    if (n_fail == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  initial begin
    repeat (6) @(posedge i_clock);
    i_reset_n <= 1'h1;
    rd(bzcfg_pkg::ADDR_LOW_DRIVE_CFG, s);
    `CHK("lc reset", 24'h000055, s)
    for (int k = 0; k < 24; k++) begin
      d = $random(seed);
      if (k < 8) d[3:0] = 4'(k + 1);
      if (k == 8) d = 24'hffffff;
      wr(bzcfg_pkg::ADDR_LOW_DRIVE_CFG, d);
      repeat (2) @(negedge i_clock);
      `CHK("range", d[23], o_drive_range_high_sel)
      `CHK("double", d[19], o_low_range_double_sel)
      `CHK("lc mag", d[3:0], o_low_range_magnitude_code)
      `CHK("na", na(d), o_low_current_na)
      `CHK("load", d[14:12], {o_test_load_enable, o_test_load_value_sel})
      `CHK("cmres", d[7:4], o_common_mode_resistance_sel)
      rd(bzcfg_pkg::ADDR_LOW_DRIVE_CFG, s);
      `CHK("lc read", d & 24'h8870ff, s)
    end
    // Unmapped places neither answer nor disturb the register
    wr(8'h55, 24'h0);
    rd(8'h55, s);
    `CHK("unmapped", 24'h0, s)
    rd(bzcfg_pkg::ADDR_LOW_DRIVE_CFG, s);
    `CHK("lc kept", d & 24'h8870ff, s)
    for (int m = 0; m < 4; m++) begin
      wr(bzcfg_pkg::ADDR_GENERAL_CFG, 24'(m) << 20);
      @(negedge i_clock);
      `CHK("step", m != 0, o_step_changed)
      for (int c = 0; c < 16; c++) begin
        {r, l, g} = 6'($random(seed));
        wr(bzcfg_pkg::ADDR_MAIN_IMP_CFG,
           {r, 9'h0, l, 4'(c), 1'h0, g, 4'h0});
        repeat (2) @(negedge i_clock);
        `CHK("mag", g, o_drive_magnitude_code)
        `CHK("lpf sel", l, o_impedance_lowpass_sel)
        rd(bzcfg_pkg::ADDR_FREQ_HZ, s);
        `CHK("freq rd", fhz(2'(m), 4'(c)), s)
        `CHK("freq", fhz(2'(m), 4'(c)), o_modulation_freq_hz)
        `CHK("lpf on", l != 2'h0, o_lowpass_enable)
        `CHK("rate", r, o_impedance_sample_rate_sel)
        `CHK("disc", 1'h1, o_discontinuity)
        rd(bzcfg_pkg::ADDR_STATUS, s);
        `CHK("subst", r && l[1], s[0])
        `CHK("mag bad", !ok(4'(c), g), s[1])
      end
      wr(bzcfg_pkg::ADDR_RESYNC_CMD, 24'($random(seed)));
      @(negedge i_clock);
      `CHK("resync", 2'h2, {o_resync_pulse, o_discontinuity})
      @(negedge i_clock);
      `CHK("resync end", 1'h0, o_resync_pulse)
    end
    test_done();
  end
endmodule
`default_nettype wire
